/* verilog/ssf_regs.vh */
// Register offsets, field positions and reset values of the serial status flag block.
`ifndef SSF_REGS_VH
`define SSF_REGS_VH
`define SSF_ADDR_STATUS   4'h0
`define SSF_ADDR_RXBUF    4'h1
`define SSF_ADDR_TXBUF    4'h2
`define SSF_ADDR_CONTROL  4'h3
`define SSF_ADDR_IRQ_STAT 4'h4
`define SSF_ADDR_IRQ_EN   4'h5
`define SSF_ADDR_IRQ_CLR  4'h6
`define SSF_STATUS_RESET  8'h84
`define SSF_BIT_TX_BUFFER_EMPTY_FLAG      7
`define SSF_BIT_RX_BUFFER_FULL_FLAG      6
`define SSF_BIT_OVR       5
`define SSF_BIT_FRM       4
`define SSF_BIT_PAR       3
`define SSF_BIT_TEND      2
`define SSF_CTL_TX_EN     0
`define SSF_CTL_RX_EN     1
`define SSF_CTL_SYNC      2
`define SSF_CTL_TWO_STOP  3
`define SSF_IRQ_TXE       0
`define SSF_IRQ_RXF       1
`define SSF_IRQ_OVR       2
`define SSF_IRQ_FRM       3
`endif

/* verilog/ssf_status_flags.v */
// Status flag logic of the serial communication unit with an Avalon-MM register slave.
//
// Contract
// RL1: Software writes of one never set flags.
// RL2: Status loads 84 hex on reset, standby.
// RL3: Transmit-empty sets when disabled or buffer moves.
// RL4: Transmit-empty clears by read-then-zero or buffer write.
// RL5: Receive-full sets on error-free reception transfer.
// RL6: Receive-full clears by read-then-zero or buffer read.
// RL7: Error or disabled receive leaves buffer, flag alone; a framing error still loads the buffer here.
// RL8: Completion while receive-full raises overrun, drops byte.
// RL9: Overrun flag sets on overrun, software clears only.
// RL10: Overrun keeps old buffer byte, drops later bytes.
// RL11: Overrun stalls reception, also transmission when synchronous.
// RL12: Disabling reception keeps overrun and framing flags.
// RL13: Framing flag sets on framing error, software clears.
// RL14: Only first stop bit checked with two.
// RL15: Framing error stores byte but not receive-full.
// RL16: Framing flag stalls reception, synchronous blocks both.
// RL17: Enabled buffer write clears empty, starts transmission.
// RL18: Zero-write clear accepted only after reading one.
`timescale 1ns/100ps
`include "ssf_regs.vh"

module ssf_status_flags (
	// Clock and reset
	input  wire        i_sys_clk,
	input  wire        i_rst,
	input  wire        i_standby,
	// Avalon-MM slave
	input  wire [3:0]  i_avs_address,
	input  wire        i_avs_read,
	input  wire        i_avs_write,
	input  wire [31:0] i_avs_writedata,
	output reg  [31:0] o_avs_readdata,
	output wire        o_avs_waitrequest,
	// Transmit engine
	input  wire        i_tx_load,
	input  wire        i_tx_last_bit,
	output reg  [7:0]  o_tx_data,
	output reg         o_tx_start,
	output wire        o_tx_enable,
	// Receive engine
	input  wire        i_rx_done,
	input  wire [7:0]  i_rx_data,
	input  wire        i_rx_stop1,
	input  wire        i_rx_stop2,
	input  wire        i_rx_parity_err,
	output wire        o_rx_enable,
	output wire        o_sync_mode,
	output wire        o_two_stop,
	// Interrupt
	output wire        o_irq
);

	reg  [7:0]  status;
	reg  [7:0]  rx_buffer;
	reg  [3:0]  control;
	reg  [3:0]  irq_stat;
	reg  [3:0]  irq_en;
	reg  [4:0]  seen_one;
	reg         ack;
	wire        flag_rst;
	wire        rd_go;
	wire        wr_go;
	wire        wr_status;
	wire        tx_en;
	wire        rx_en;
	wire        sync;
	wire        err_block;
	wire        rx_block;
	wire        frame_err;
	wire        rx_accept;
	wire        rx_overrun;
	wire        rx_good;
	wire        rx_frame;
	wire        tx_write;
	wire        rd_rxbuf;
	wire [4:0]  clr_ok;
	wire [3:0]  irq_evt;

	assign flag_rst          = i_rst | i_standby; // see RL2
	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack;
	assign rd_go             = i_avs_read & ack;
	assign wr_go             = i_avs_write & ack;
	assign wr_status         = wr_go && (i_avs_address == `SSF_ADDR_STATUS);
	assign tx_en             = control[`SSF_CTL_TX_EN];
	assign rx_en             = control[`SSF_CTL_RX_EN];
	assign sync              = control[`SSF_CTL_SYNC];
	assign o_tx_enable       = tx_en;
	assign o_rx_enable       = rx_en;
	assign o_sync_mode       = sync;
	assign o_two_stop        = control[`SSF_CTL_TWO_STOP];
	assign err_block         = status[`SSF_BIT_OVR] | status[`SSF_BIT_FRM] | status[`SSF_BIT_PAR];
	assign rx_block          = err_block; // see RL11 see RL16
	// Only the first stop bit counts; the second is ignored.
	assign frame_err         = ~i_rx_stop1 & ~(1'b0 & i_rx_stop2); // see RL14
	assign rx_accept         = i_rx_done & rx_en & ~rx_block; // see RL10
	assign rx_overrun        = rx_accept & status[`SSF_BIT_RX_BUFFER_FULL_FLAG]; // see RL8
	assign rx_frame          = rx_accept & ~rx_overrun & frame_err;
	assign rx_good           = rx_accept & ~rx_overrun & ~frame_err & ~i_rx_parity_err;
	assign tx_write          = wr_go && (i_avs_address == `SSF_ADDR_TXBUF) && tx_en && ~(sync & err_block);
	assign rd_rxbuf          = rd_go && (i_avs_address == `SSF_ADDR_RXBUF);
	assign clr_ok            = seen_one & ~{i_avs_writedata[`SSF_BIT_TX_BUFFER_EMPTY_FLAG], i_avs_writedata[`SSF_BIT_RX_BUFFER_FULL_FLAG],
	                           i_avs_writedata[`SSF_BIT_OVR], i_avs_writedata[`SSF_BIT_FRM],
	                           i_avs_writedata[`SSF_BIT_PAR]} & {5{wr_status}}; // see RL18 see RL1
	assign irq_evt           = {rx_frame, rx_overrun, rx_good, i_tx_load & tx_en};
	assign o_irq             = |(irq_stat & irq_en);

	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			ack <= 1'b0;
		end else begin
			ack <= (i_avs_read | i_avs_write) & ~ack;
		end
	end

	always @(posedge i_sys_clk) begin
		if (flag_rst) begin
			status   <= `SSF_STATUS_RESET; // see RL2
			seen_one <= 5'h00;
		end else begin
			// Transmit-empty: set wins over clear.
			if (~tx_en || i_tx_load) begin
				status[`SSF_BIT_TX_BUFFER_EMPTY_FLAG] <= 1'b1; // see RL3 see RL17
			end else if (tx_write || clr_ok[4]) begin
				status[`SSF_BIT_TX_BUFFER_EMPTY_FLAG] <= 1'b0; // see RL4 see RL17
			end
			if (~tx_en || (i_tx_last_bit && status[`SSF_BIT_TX_BUFFER_EMPTY_FLAG])) begin
				status[`SSF_BIT_TEND] <= 1'b1;
			end else if (tx_write || clr_ok[4]) begin
				status[`SSF_BIT_TEND] <= 1'b0;
			end
			if (rx_good) begin
				status[`SSF_BIT_RX_BUFFER_FULL_FLAG] <= 1'b1; // see RL5 see RL7
			end else if (rd_rxbuf || clr_ok[3]) begin
				status[`SSF_BIT_RX_BUFFER_FULL_FLAG] <= 1'b0; // see RL6
			end
			if (rx_overrun) begin
				status[`SSF_BIT_OVR] <= 1'b1; // see RL9 see RL12
			end else if (clr_ok[2]) begin
				status[`SSF_BIT_OVR] <= 1'b0; // see RL9
			end
			if (rx_frame) begin
				status[`SSF_BIT_FRM] <= 1'b1; // see RL13 see RL12
			end else if (clr_ok[1]) begin
				status[`SSF_BIT_FRM] <= 1'b0; // see RL13
			end
			if (rx_accept && ~rx_overrun && ~frame_err && i_rx_parity_err) begin
				status[`SSF_BIT_PAR] <= 1'b1;
			end else if (clr_ok[0]) begin
				status[`SSF_BIT_PAR] <= 1'b0;
			end
			// A read of one arms the clear, using the value that the read returns; any status write disarms it.
			if (i_avs_read && ~ack && (i_avs_address == `SSF_ADDR_STATUS)) begin
				seen_one <= {status[`SSF_BIT_TX_BUFFER_EMPTY_FLAG], status[`SSF_BIT_RX_BUFFER_FULL_FLAG], status[`SSF_BIT_OVR],
				             status[`SSF_BIT_FRM], status[`SSF_BIT_PAR]}; // see RL18
			end else if (wr_status) begin
				seen_one <= 5'h00;
			end
		end
	end

	always @(posedge i_sys_clk) begin
		if (flag_rst) begin
			rx_buffer <= 8'h00;
		end else if (rx_good || rx_frame) begin
			rx_buffer <= i_rx_data; // see RL15 see RL7 see RL10
		end
	end

	always @(posedge i_sys_clk) begin
		if (flag_rst) begin
			control    <= 4'h0;
			irq_stat   <= 4'h0;
			irq_en     <= 4'h0;
			o_tx_data  <= 8'h00;
			o_tx_start <= 1'b0;
		end else begin
			o_tx_start <= tx_write; // see RL17
			if (tx_write) begin
				o_tx_data <= i_avs_writedata[7:0];
			end
			if (wr_go && (i_avs_address == `SSF_ADDR_CONTROL)) begin
				control <= i_avs_writedata[3:0];
			end
			if (wr_go && (i_avs_address == `SSF_ADDR_IRQ_EN)) begin
				irq_en <= i_avs_writedata[3:0];
			end
			if (wr_go && (i_avs_address == `SSF_ADDR_IRQ_CLR)) begin
				irq_stat <= irq_evt | (irq_stat & ~i_avs_writedata[3:0]);
			end else begin
				irq_stat <= irq_stat | irq_evt;
			end
		end
	end

	always @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_avs_readdata <= 32'h00000000;
		end else if (i_avs_read && ~ack) begin
			// Loaded in the wait cycle so that the data stand at the completing edge.
			if (i_avs_address == `SSF_ADDR_STATUS) begin
				o_avs_readdata <= {24'h000000, status};
			end else if (i_avs_address == `SSF_ADDR_RXBUF) begin
				o_avs_readdata <= {24'h000000, rx_buffer};
			end else if (i_avs_address == `SSF_ADDR_CONTROL) begin
				o_avs_readdata <= {28'h0000000, control};
			end else if (i_avs_address == `SSF_ADDR_IRQ_STAT) begin
				o_avs_readdata <= {28'h0000000, irq_stat};
			end else if (i_avs_address == `SSF_ADDR_IRQ_EN) begin
				o_avs_readdata <= {28'h0000000, irq_en};
			end else begin
				o_avs_readdata <= 32'h00000000;
			end
		end
	end

endmodule // ssf_status_flags

/* tb/ssf_checker.sv */
// Assertion checker for the serial status flag block.
`timescale 1ns/100ps
module ssf_checker (
	input wire        i_sys_clk, i_rst, i_standby, i_avs_read, i_avs_write,
	input wire [3:0]  i_avs_address,
	input wire [31:0] i_avs_writedata, o_avs_readdata,
	input wire        o_avs_waitrequest, o_tx_start, o_tx_enable, o_sync_mode, o_irq,
	input wire [7:0]  o_tx_data
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	wire req = i_avs_read | i_avs_write;
	wire rdone = i_avs_read & !o_avs_waitrequest;
	wire txw = i_avs_write & !o_avs_waitrequest & (i_avs_address == 4'h2);
	wire txok = txw & o_tx_enable & !o_sync_mode;
	a_one_wait: assert property (req & o_avs_waitrequest |=> !o_avs_waitrequest) else $error("no answer");
	a_idle_ready: assert property (!req |-> !o_avs_waitrequest) else $error("idle wait");
	a_tx_start: assert property (txok |=> o_tx_start) else $error("no start");
	a_tx_data: assert property (txok |=> o_tx_data == $past(i_avs_writedata[7:0])) else $error("data");
	a_tx_off: assert property (txw & !o_tx_enable |=> !o_tx_start) else $error("start off");
	a_start_cause: assert property (o_tx_start |-> $past(txw)) else $error("stray start");
	a_empty_off: assert property (rdone & i_avs_address == 4'h0 & !o_tx_enable
		|-> o_avs_readdata[7]) else $error("empty off");
	a_high_zero: assert property (rdone |-> o_avs_readdata[31:8] == 24'h0) else $error("high bits");
	a_irq_reset: assert property ($fell(i_rst) |-> !o_irq) else $error("irq reset");
	a_stby_irq: assert property (i_standby |=> !o_irq) else $error("irq standby");
	c_tx: cover property (txok);
	c_irq: cover property (o_irq);
	c_rbuf: cover property (rdone & i_avs_address == 4'h1);
endmodule // ssf_checker
bind ssf_status_flags ssf_checker chk (.*);

/* tb/ssf_peer.sv */
// Far-side serial engine model: receive frames and transmit drain.
`timescale 1ns/100ps
module ssf_peer (
	input  wire       i_clk, i_start,
	output reg        o_done, o_load, o_last, o_stop1, o_stop2, o_perr,
	output reg  [7:0] o_data
);
	initial {o_done, o_load, o_last, o_stop1, o_stop2, o_perr, o_data} = 0;
	always @(posedge i_clk) if (i_start) begin
		repeat (6) @(posedge i_clk);
		o_load <= 1;
		@(posedge i_clk) o_load <= 0;
		repeat (4) @(posedge i_clk);
		o_last <= 1;
		@(posedge i_clk) o_last <= 0;
	end
	task frame(input [7:0] d, input s);
		begin
			{o_data, o_stop1, o_stop2, o_done} <= {d, s, !s, 1'b1};
			@(posedge i_clk);
			{o_data, o_stop1, o_stop2, o_done} <= {~d, !s, s, 1'b0};
			@(posedge i_clk);
		end
	endtask
endmodule // ssf_peer

/* tb/ssf_status_flags_tb_top.sv */
// Self-checking testbench of the serial status flag block.
`timescale 1ns/100ps
module ssf_status_flags_tb_top;
	reg         i_sys_clk = 0, i_rst = 1, i_standby = 0, i_avs_read = 0, i_avs_write = 0;
	reg  [3:0]  i_avs_address = 0;
	reg  [31:0] i_avs_writedata = 0, q;
	wire [31:0] o_avs_readdata;
	wire [7:0]  o_tx_data, i_rx_data;
	wire        o_avs_waitrequest, i_tx_load, i_tx_last_bit, o_tx_start, o_tx_enable, i_rx_done, i_rx_stop1;
	wire        i_rx_stop2, i_rx_parity_err, o_rx_enable, o_sync_mode, o_two_stop, o_irq;
	integer     mismatches = 0, tests_run = 0;
	always #20 i_sys_clk = !i_sys_clk;
	ssf_status_flags uut (.*);
	ssf_peer m (.i_clk(i_sys_clk), .i_start(o_tx_start), .o_done(i_rx_done), .o_load(i_tx_load),
		.o_last(i_tx_last_bit), .o_stop1(i_rx_stop1), .o_stop2(i_rx_stop2), .o_perr(i_rx_parity_err),
		.o_data(i_rx_data));
	task test_done;
		begin
			$display("tests %0d mismatches %0d", tests_run, mismatches);
			if (mismatches == 0 && tests_run > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	task chk(input [15:0] n, input [31:0] e, input [31:0] g);
		begin
			tests_run = tests_run + 1;
			if (g !== e) begin
				mismatches = mismatches + 1;
				$display("wrong value %s expected %h seen %h", n, e, g);
			end
		end
	endtask
	task acc(input w, input [3:0] a, input [31:0] d);
		begin
			{i_avs_write, i_avs_read, i_avs_address, i_avs_writedata} <= {w, !w, a, d};
			@(posedge i_sys_clk);
			while (o_avs_waitrequest) @(posedge i_sys_clk);
			q = o_avs_readdata;
			{i_avs_write, i_avs_read} <= 0;
			@(posedge i_sys_clk);
		end
	endtask
	task rc(input [15:0] n, input [3:0] a, input [7:0] k, input [31:0] e);
		begin
			acc(0, a, 0);
			chk(n, e, q & k);
		end
	endtask
	initial begin
		repeat (16) @(posedge i_sys_clk);
		i_rst <= 0;
		@(posedge i_sys_clk);
		rc("st", 0, 8'hFF, 8'h84);
		acc(1, 0, 8'hFF);
		rc("st", 0, 8'hFF, 8'h84);
		acc(1, 3, 3);
		acc(1, 2, 8'h5A);
		rc("st", 0, 8'hF8, 0);
		repeat (8) @(posedge i_sys_clk);
		rc("st", 0, 8'hF8, 8'h80);
		acc(1, 0, 8'h7F);
		rc("st", 0, 8'hF8, 0);
		$display("test tx done");
		m.frame(8'hA5, 1);
		rc("st", 0, 8'hF8, 8'h40);
		rc("rb", 1, 8'hFF, 8'hA5);
		rc("st", 0, 8'hF8, 0);
		m.frame(8'h11, 1);
		m.frame(8'h22, 1);
		rc("st", 0, 8'hF8, 8'h60);
		rc("rb", 1, 8'hFF, 8'h11);
		m.frame(8'h33, 1);
		rc("st", 0, 8'hF8, 8'h20);
		rc("rb", 1, 8'hFF, 8'h11);
		acc(1, 3, 1);
		rc("st", 0, 8'hF8, 8'h20);
		acc(1, 0, 8'hFF);
		acc(1, 0, 0);
		rc("st", 0, 8'hF8, 8'h20);
		acc(1, 0, 0);
		rc("st", 0, 8'hF8, 0);
		$display("test overrun done");
		acc(1, 3, 3);
		m.frame(8'h77, 0);
		rc("st", 0, 8'hF8, 8'h10);
		rc("rb", 1, 8'hFF, 8'h77);
		m.frame(8'h88, 1);
		rc("rb", 1, 8'hFF, 8'h77);
		acc(1, 3, 0);
		rc("st", 0, 8'hF8, 8'h90);
		$display("test framing done");
		rc("is", 4, 8'h0F, 8'h0F);
		acc(1, 5, 8);
		chk("iq", 1, o_irq);
		acc(1, 6, 8);
		acc(1, 4, 0);
		rc("is", 4, 8'h0F, 8'h07);
		chk("iq", 0, o_irq);
		rc("un", 15, 8'hFF, 0);
		$display("test irq done");
		acc(1, 5, 8'h0F);
		i_standby <= 1;
		@(posedge i_sys_clk) i_standby <= 0;
		@(posedge i_sys_clk);
		rc("st", 0, 8'hFF, 8'h84);
		chk("iq", 0, o_irq);
		$display("test standby done");
		test_done;
	end
	initial begin
		repeat (5000) @(posedge i_sys_clk);
		mismatches = mismatches + 1;
		test_done;
	end
endmodule // ssf_status_flags_tb_top
